// File: logic/mspt_pkg.sv
// Package: register map, mode fields and codes of the PWM timer group
`default_nettype none
package mspt_pkg;
    localparam int NCH = 8;
    localparam int CW = 16;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_START = 8'h04;
    localparam logic [7:0] OFS_STOP = 8'h08;
    localparam logic [7:0] OFS_RUN = 8'h0C;
    localparam logic [7:0] OFS_LVL = 8'h10;
    localparam logic [7:0] OFS_OE = 8'h14;
    localparam logic [7:0] OFS_POL = 8'h18;
    localparam logic [7:0] OFS_OM = 8'h1C;
    // Per-channel groups: address bits 7:5 pick the group, 4:2 the channel
    localparam logic [2:0] GRP_MODE = 3'h1;
    localparam logic [2:0] GRP_RELOAD = 3'h2;
    localparam logic [2:0] GRP_COUNT = 3'h3;

    // Control register field positions
    localparam int CTRL_PWR_BIT = 0;
    localparam int CTRL_PSA_LSB = 4;
    localparam int CTRL_PSB_LSB = 8;

    // Reset values
    localparam logic [15:0] RST_MODE = 16'h0000;
    localparam logic [15:0] RST_RELOAD = 16'h0000;
    localparam logic [7:0] RST_BITS = 8'h00;
    localparam logic [3:0] RST_PS = 4'h0;

    // Field codes
    localparam logic [2:0] TRIG_SW = 3'h0;
    localparam logic [2:0] TRIG_MASTER = 3'h4;
    localparam logic [1:0] OPCLK_A = 2'h0;
    localparam logic [1:0] OPCLK_B = 2'h2;
    localparam logic [2:0] MODE_INTERVAL = 3'h0;
    localparam logic [2:0] MODE_ONECOUNT = 3'h4;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic rsv_a;
        logic cnt_clk_sel;
        logic master_sel;
        logic [2:0] trig_sel;
        logic [1:0] edge_sel;
        logic [1:0] rsv_b;
        logic [2:0] op_mode;
        logic opt_bit;
    } mspt_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } mspt_apb_req_t;
endpackage
`default_nettype wire

// File: logic/mspt_timer.sv
// Master/slave PWM timer group with APB register access
// Functional notes
// RQ1 - Master start-interrupt option raises end pulse at count start too.
// RQ2 - Trigger select 000 starts a channel by software start write only.
// RQ3 - Master select bit honoured on channels 2,4,6; channel 0 always master.
// RQ4 - Clock select 00 takes tap A, 10 tap B; count select 0 counts.
// RQ5 - Master output mode clears polarity; masters keep level and enable 0.
// RQ6 - Trigger-during-operation lets a counting slave restart on trigger.
// RQ7 - Slave trigger select 100 uses its master's end pulse.
// RQ8 - Software sets input edge field to 00 in PWM use.
// RQ9 - Output bit written 0 drives pin low, 1 drives pin high.
// RQ10 - Output enable 1 lets counting change the pin; 0 blocks it.
// RQ11 - Polarity 0 active-high output, 1 active-low output.
// RQ12 - Slave output mode: set by master trigger, cleared by own end.
// RQ13 - Power enable 0 stops clock and ignores writes; 1 starts stopped.
// RQ14 - Stopped slave holds pin at written output level.
// RQ15 - Master period equals reload plus one count clocks.
// RQ16 - Slave reload beyond master reload plus one gives full duty.
// RQ17 - Slave loads reload on master pulse, counts to zero, pulses, waits.
// RQ18 - Slave output active one count clock after trigger, inactive at zero.
// RQ19 - Slaves above a master up to channel 7 share that master; code triggers each slave from its nearest lower master.
// RQ20 - Reload values reach counters only on start or master end pulse.
// RQ21 - Software rewrites period and duty right after a master end pulse.
// RQ22 - Software sets mode, polarity, level, then enable during setup.
// RQ23 - Master at zero pulses, reloads and repeats until stop written.
// RQ24 - Slave reload of zero gives zero duty.
//
// Implementation choices: the APB register port and the placing of the registers.
`default_nettype none
module mspt_timer (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire mspt_pkg::mspt_apb_req_t i_apb_req,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [7:0] o_pwm_out,
    output logic [7:0] o_end_irq
);
    logic pwr_q, pwr_d;
    logic [3:0] psa_q, psa_d, psb_q, psb_d;
    logic [15:0] pre_q, pre_d;
    logic [31:0] rdata_q, rdata_d;
    mspt_pkg::mspt_mode_t mode_q [8];
    mspt_pkg::mspt_mode_t mode_d [8];
    logic [15:0] rld_q [8];
    logic [15:0] rld_d [8];
    logic [15:0] cnt_q [8];
    logic [15:0] cnt_d [8];
    logic [7:0] en_q, en_d, act_q, act_d, pend_q, pend_d;
    logic [7:0] lvl_q, lvl_d, oe_q, oe_d, pol_q, pol_d, om_q, om_d;
    logic [7:0] irq_q, irq_d;
    logic [7:0] tk_ch, is_mst, hw_v;
    logic tk_a, tk_b, setup, acc, wr;
    logic [7:0] addr;
    logic [31:0] wd;
    logic [2:0] ach;

    function automatic logic tap_tick(input logic [15:0] pre, input logic [3:0] sel);
        logic [15:0] mask;
        mask = 16'((32'h1 << sel) - 32'h1);
        return (pre & mask) == mask;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a[7] == 1'b0);
    endfunction

    assign addr = i_apb_req.paddr;
    assign wd = i_apb_req.pwdata;
    assign ach = addr[4:2];
    assign setup = i_apb_req.psel & ~i_apb_req.penable;
    assign acc = i_apb_req.psel & i_apb_req.penable & i_clk_en;
    assign wr = acc & i_apb_req.pwrite & addr_ok(addr);
    assign o_pready = acc;
    assign o_pslverr = acc & ~addr_ok(addr);
    assign o_prdata = rdata_q;
    assign o_pwm_out = lvl_q;
    assign o_end_irq = irq_q;

    // RQ4 - prescaler taps pick count clock
    assign tk_a = tap_tick(pre_q, psa_q);
    assign tk_b = tap_tick(pre_q, psb_q);

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ch
            // RQ4 - clock select and count clock select
            assign tk_ch[g] = pwr_q & ~mode_q[g].cnt_clk_sel
                & (mode_q[g].clk_sel[1] ? tk_b : tk_a);
            // RQ3 - channel 0 always master
            assign is_mst[g] = (g == 0) | mode_q[g].master_sel;
        end
    endgenerate

    // Bus-side configuration registers and read data
    always_comb begin
        pwr_d = pwr_q;
        psa_d = psa_q;
        psb_d = psb_q;
        rdata_d = rdata_q;
        mode_d = mode_q;
        rld_d = rld_q;
        pre_d = pwr_q ? pre_q + 16'h0001 : 16'h0000;
        if (wr && addr == mspt_pkg::OFS_CTRL) begin
            pwr_d = wd[mspt_pkg::CTRL_PWR_BIT];
            if (pwr_q) begin
                psa_d = wd[mspt_pkg::CTRL_PSA_LSB +: 4];
                psb_d = wd[mspt_pkg::CTRL_PSB_LSB +: 4];
            end
        end
        // RQ13 - writes ignored while unit is unpowered
        if (wr && pwr_q && addr[7:5] == mspt_pkg::GRP_MODE) begin
            mode_d[ach] = mspt_pkg::mspt_mode_t'(wd[15:0]);
            // RQ3 - master select only on channels 2, 4, 6
            if (ach == 3'h0 || ach[0]) begin
                mode_d[ach].master_sel = 1'b0;
            end
        end
        // RQ20 - writes only store the reload value
        if (wr && pwr_q && addr[7:5] == mspt_pkg::GRP_RELOAD) begin
            rld_d[ach] = wd[15:0];
        end
        // RQ13 - power-off initialises the unit
        if (!pwr_q) begin
            psa_d = mspt_pkg::RST_PS;
            psb_d = mspt_pkg::RST_PS;
            for (int i = 0; i < 8; i++) begin
                mode_d[i] = mspt_pkg::mspt_mode_t'(mspt_pkg::RST_MODE);
                rld_d[i] = mspt_pkg::RST_RELOAD;
            end
        end
        if (setup) begin
            rdata_d = 32'h0000_0000;
            case (addr[7:5])
                3'h0: begin
                    case (addr)
                        mspt_pkg::OFS_CTRL:
                            rdata_d = {20'h0_0000, psb_q, psa_q, 3'h0, pwr_q};
                        mspt_pkg::OFS_RUN: rdata_d = {24'h00_0000, en_q};
                        mspt_pkg::OFS_LVL: rdata_d = {24'h00_0000, lvl_q};
                        mspt_pkg::OFS_OE: rdata_d = {24'h00_0000, oe_q};
                        mspt_pkg::OFS_POL: rdata_d = {24'h00_0000, pol_q};
                        mspt_pkg::OFS_OM: rdata_d = {24'h00_0000, om_q};
                        default: rdata_d = 32'h0000_0000;
                    endcase
                end
                mspt_pkg::GRP_MODE: rdata_d = {16'h0000, mode_q[ach]};
                mspt_pkg::GRP_RELOAD: rdata_d = {16'h0000, rld_q[ach]};
                mspt_pkg::GRP_COUNT: rdata_d = {16'h0000, cnt_q[ach]};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwr_q <= 1'b0;
            psa_q <= mspt_pkg::RST_PS;
            psb_q <= mspt_pkg::RST_PS;
            pre_q <= 16'h0000;
            rdata_q <= 32'h0000_0000;
            for (int i = 0; i < 8; i++) begin
                mode_q[i] <= mspt_pkg::mspt_mode_t'(mspt_pkg::RST_MODE);
                rld_q[i] <= mspt_pkg::RST_RELOAD;
            end
        end else if (i_clk_en) begin
            pwr_q <= pwr_d;
            psa_q <= psa_d;
            psb_q <= psb_d;
            pre_q <= pre_d;
            rdata_q <= rdata_d;
            mode_q <= mode_d;
            rld_q <= rld_d;
        end
    end

    // Channel counters, outputs and end pulses
    always_comb begin
        logic trig;
        logic sw_go;
        logic sw_halt;
        logic go;
        logic ev_set;
        logic ev_clr;
        mspt_pkg::mspt_mode_t m;
        trig = 1'b0;
        sw_go = 1'b0;
        sw_halt = 1'b0;
        go = 1'b0;
        ev_set = 1'b0;
        ev_clr = 1'b0;
        m = mode_q[0];
        en_d = en_q;
        act_d = act_q;
        pend_d = pend_q;
        cnt_d = cnt_q;
        lvl_d = lvl_q;
        oe_d = oe_q;
        pol_d = pol_q;
        om_d = om_q;
        irq_d = 8'h00;
        hw_v = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m = mode_q[i];
            ev_set = 1'b0;
            ev_clr = 1'b0;
            sw_go = wr && pwr_q && addr == mspt_pkg::OFS_START && wd[i];
            sw_halt = wr && pwr_q && addr == mspt_pkg::OFS_STOP && wd[i];
            // RQ7 - master end pulse triggers slaves above it
            // RQ19 - nearest lower master drives each slave
            hw_v[i] = (m.trig_sel == mspt_pkg::TRIG_MASTER) && trig && !is_mst[i]
                && (en_q[i] || sw_go);
            // RQ2 - software-only start for code 000
            go = (m.trig_sel == mspt_pkg::TRIG_SW) ? sw_go : hw_v[i];
            if (sw_halt) begin
                // RQ23 - stop write ends repetition
                en_d[i] = 1'b0;
                act_d[i] = 1'b0;
                pend_d[i] = 1'b0;
            end else if (m.op_mode == mspt_pkg::MODE_INTERVAL) begin
                if (sw_go) begin
                    en_d[i] = 1'b1;
                end
                if (go) begin
                    en_d[i] = 1'b1;
                    act_d[i] = 1'b1;
                    cnt_d[i] = rld_q[i];
                    // RQ1 - end pulse at count start
                    irq_d[i] = m.opt_bit;
                end else if (act_q[i] && tk_ch[i]) begin
                    // RQ15 - reload plus one clocks per period
                    // RQ23 - pulse, reload and keep counting
                    if (cnt_q[i] == 16'h0000) begin
                        irq_d[i] = 1'b1;
                        cnt_d[i] = rld_q[i];
                    end else begin
                        cnt_d[i] = cnt_q[i] - 16'h0001;
                    end
                end
            end else begin
                if (sw_go) begin
                    en_d[i] = 1'b1;
                end
                // RQ6 - restart while counting when allowed
                // RQ20 - reload enters counter on master pulse
                // RQ16 - retrigger before zero keeps output fully active
                if (go && (!act_q[i] || m.opt_bit)) begin
                    act_d[i] = 1'b1;
                    pend_d[i] = 1'b1;
                    cnt_d[i] = rld_q[i];
                end else if (act_q[i] && tk_ch[i]) begin
                    // RQ18 - active one count clock after trigger
                    if (pend_q[i]) begin
                        pend_d[i] = 1'b0;
                        ev_set = 1'b1;
                    end
                    // RQ17 - end at zero, pulse and wait
                    if (cnt_q[i] == 16'h0000) begin
                        irq_d[i] = 1'b1;
                        act_d[i] = 1'b0;
                        ev_clr = 1'b1;
                    end else begin
                        cnt_d[i] = cnt_q[i] - 16'h0001;
                    end
                end
            end
            if (is_mst[i]) begin
                trig = irq_d[i];
            end
            // RQ9 - level write takes effect only while output enable is 0
            if (wr && pwr_q && addr == mspt_pkg::OFS_LVL && !oe_q[i]) begin
                lvl_d[i] = wd[i];
            end
            if (wr && pwr_q && addr == mspt_pkg::OFS_OE) begin
                oe_d[i] = wd[i];
            end
            if (wr && pwr_q && addr == mspt_pkg::OFS_POL) begin
                pol_d[i] = wd[i];
            end
            if (wr && pwr_q && addr == mspt_pkg::OFS_OM) begin
                om_d[i] = wd[i];
            end
            // RQ10 - enable gates counting events onto the pin
            // RQ12 - slave mode: set by trigger, cleared by end
            // RQ11 - polarity picks the active level
            // RQ24 - clear after set yields zero duty
            // RQ14 - counting moves the pin only on these count events
            if (oe_q[i] && om_q[i] && !is_mst[i]) begin
                if (ev_set) begin
                    lvl_d[i] = ~pol_q[i];
                end
                if (ev_clr) begin
                    lvl_d[i] = pol_q[i];
                end
            end
            // RQ5 - master output mode clears polarity
            if (!om_d[i]) begin
                pol_d[i] = 1'b0;
            end
            // RQ5 - master keeps level and enable at 0
            if (is_mst[i]) begin
                lvl_d[i] = 1'b0;
                oe_d[i] = 1'b0;
            end
            // RQ13 - unpowered unit held initialised
            if (!pwr_q) begin
                en_d[i] = 1'b0;
                act_d[i] = 1'b0;
                pend_d[i] = 1'b0;
                cnt_d[i] = 16'h0000;
                lvl_d[i] = 1'b0;
                oe_d[i] = 1'b0;
                pol_d[i] = 1'b0;
                om_d[i] = 1'b0;
                irq_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_q <= mspt_pkg::RST_BITS;
            act_q <= mspt_pkg::RST_BITS;
            pend_q <= mspt_pkg::RST_BITS;
            lvl_q <= mspt_pkg::RST_BITS;
            oe_q <= mspt_pkg::RST_BITS;
            pol_q <= mspt_pkg::RST_BITS;
            om_q <= mspt_pkg::RST_BITS;
            irq_q <= mspt_pkg::RST_BITS;
            for (int i = 0; i < 8; i++) begin
                cnt_q[i] <= 16'h0000;
            end
        end else if (i_clk_en) begin
            en_q <= en_d;
            act_q <= act_d;
            pend_q <= pend_d;
            lvl_q <= lvl_d;
            oe_q <= oe_d;
            pol_q <= pol_d;
            om_q <= om_d;
            irq_q <= irq_d;
            cnt_q <= cnt_d;
        end
    end

    // Checks on channel 0 as master and channel 1 as slave, plus polarity and power-off checks on all channels
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    logic start0, lvl1_wr;
    assign start0 = wr && pwr_q && addr == mspt_pkg::OFS_START && wd[0];
    assign lvl1_wr = wr && pwr_q && addr == mspt_pkg::OFS_LVL;

    chk_start_irq: assert property ( // RQ1
        start0 && mode_q[0].opt_bit && mode_q[0].op_mode == mspt_pkg::MODE_INTERVAL
        && mode_q[0].trig_sel == mspt_pkg::TRIG_SW |=> irq_q[0] && act_q[0])
        else $error("master start did not raise end pulse");
    chk_sw_start_only: assert property ( // RQ2
        $rose(en_q[0]) && mode_q[0].trig_sel == mspt_pkg::TRIG_SW |-> $past(start0))
        else $error("master enabled without software start");
    chk_ch0_master: assert property ( // RQ3
        mode_q[0].master_sel == 1'b0 && is_mst[0])
        else $error("channel 0 not master");
    chk_pol_cleared: assert property ( // RQ5
        (pol_q & ~om_q) == 8'h00 && lvl_q[0] == 1'b0 && oe_q[0] == 1'b0)
        else $error("master output bits not held at 0");
    chk_pin_hold: assert property ( // RQ14
        i_clk_en && pwr_q && !act_q[1] && !pend_q[1] && !lvl1_wr |=> $stable(lvl_q[1]))
        else $error("stopped slave pin changed");
    chk_oe_blocks: assert property ( // RQ10
        i_clk_en && pwr_q && !oe_q[1] && !lvl1_wr |=> $stable(lvl_q[1]))
        else $error("disabled output changed by counting");
    chk_master_wrap: assert property ( // RQ23
        i_clk_en && pwr_q && act_q[0] && tk_ch[0] && cnt_q[0] == 16'h0000 && !start0
        && mode_q[0].op_mode == mspt_pkg::MODE_INTERVAL
        && !(wr && addr == mspt_pkg::OFS_STOP)
        |=> irq_q[0] && cnt_q[0] == $past(rld_q[0]))
        else $error("master did not reload at zero");
    chk_slave_end: assert property ( // RQ17
        i_clk_en && pwr_q && act_q[1] && tk_ch[1] && cnt_q[1] == 16'h0000 && !hw_v[1]
        && mode_q[1].op_mode == mspt_pkg::MODE_ONECOUNT
        && !(wr && (addr == mspt_pkg::OFS_STOP || addr == mspt_pkg::OFS_START))
        |=> irq_q[1] && !act_q[1])
        else $error("slave did not end at zero");
    chk_pwm_active: assert property ( // RQ18
        i_clk_en && pwr_q && act_q[1] && pend_q[1] && tk_ch[1] && !hw_v[1]
        && oe_q[1] && om_q[1] && cnt_q[1] != 16'h0000
        && mode_q[1].op_mode == mspt_pkg::MODE_ONECOUNT
        && !(wr && (addr == mspt_pkg::OFS_STOP || addr == mspt_pkg::OFS_START))
        |=> lvl_q[1] == ~pol_q[1])
        else $error("slave output not active after trigger");
    chk_power_off: assert property ( // RQ13
        i_clk_en && !pwr_q |=> en_q == 8'h00 && lvl_q == 8'h00 && irq_q == 8'h00)
        else $error("unpowered unit not initialised");
    cov_master_period: cover property (irq_q[0] ##[1:300] irq_q[0]);
    cov_slave_end: cover property (irq_q[1] && lvl_q[1] == pol_q[1]);
    cov_retrigger: cover property (act_q[1] && hw_v[1] && mode_q[1].opt_bit);
    cov_slave_pwm: cover property ($rose(lvl_q[1]) ##[1:300] $fell(lvl_q[1]));
endmodule
`default_nettype wire

// File: verif/mspt_load_model.sv
// Load model: counts the cycles each PWM pin spends high while enabled
`default_nettype none
module mspt_load_model (
    input wire logic i_clk,
    input wire logic i_en,
    input wire logic [7:0] i_pin,
    output logic [7:0][7:0] o_high_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    // Counts clear whenever the bench is not measuring
    always_ff @(posedge i_clk) begin
        for (int c = 0; c < 8; c++) begin
            if (!i_en) begin
                o_high_cnt[c] <= 8'h00;
            end else begin
                o_high_cnt[c] <= o_high_cnt[c] + {7'h00, i_pin[c]};
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/tb.sv
// Testbench of the master/slave PWM timer group
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic meas_en = 1'b0;
    mspt_pkg::mspt_apb_req_t req = '0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [7:0] pwm, irq;
    logic [7:0][7:0] high_cnt;
    int failures = 0;
    int checked = 0;

    mspt_timer mspt_timer_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
        .i_apb_req(req), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_pwm_out(pwm), .o_end_irq(irq));
    mspt_load_model mspt_load_model_inst (.i_clk(i_core_clk), .i_en(meas_en), .i_pin(pwm),
        .o_high_cnt(high_cnt));

    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end

    function automatic logic [7:0] adr(input logic [2:0] grp, input int ch);
        return {grp, ch[2:0], 2'b00};
    endfunction

    // Setup cycle, then access held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_core_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = prdata;
        err = pslverr;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                         input logic eerr);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 32'h0, r, e);
        `CHK(nm, exp, r)
        `CHK(nm, eerr, e)
    endtask

    task automatic idle();
        req <= '0;
        @(posedge i_core_clk);
    endtask

    task automatic measure(input int n, input logic [7:0] i0, i1, h1, h2, h3, h4);
        logic [7:0] c0, c1;
        c0 = 8'h00;
        c1 = 8'h00;
        meas_en <= 1'b1;
        repeat (n) begin
            @(negedge i_core_clk);
            c0 = c0 + {7'h00, irq[0]};
            c1 = c1 + {7'h00, irq[1]};
            @(posedge i_core_clk);
        end
        meas_en <= 1'b0;
        #1;
        `CHK("master pulses", i0, c0)
        `CHK("slave pulses", i1, c1)
        `CHK("master pin", 8'h00, high_cnt[0])
        `CHK("duty pin", h1, high_cnt[1])
        `CHK("zero duty pin", h2, high_cnt[2])
        `CHK("full duty pin", h3, high_cnt[3])
        `CHK("disabled pin", h4, high_cnt[4])
        @(posedge i_core_clk);
    endtask

    task automatic t_power();
        wr(mspt_pkg::OFS_LVL, 32'h02);
        rdchk("level unpowered", mspt_pkg::OFS_LVL, 32'h00, 1'b0);
        wr(mspt_pkg::OFS_CTRL, 32'h01);
        rdchk("control", mspt_pkg::OFS_CTRL, 32'h01, 1'b0);
        wr(mspt_pkg::OFS_LVL, 32'h03);
        rdchk("level", mspt_pkg::OFS_LVL, 32'h02, 1'b0);
        `CHK("pin level", 8'h02, pwm)
        wr(mspt_pkg::OFS_POL, 32'h01);
        rdchk("master polarity", mspt_pkg::OFS_POL, 32'h00, 1'b0);
        for (int c = 0; c < 3; c++) begin
            wr(adr(mspt_pkg::GRP_MODE, c), 32'h0800);
            rdchk("master select", adr(mspt_pkg::GRP_MODE, c),
                  (c == 2) ? 32'h0800 : 32'h0, 1'b0);
        end
        rdchk("unmapped", 8'h80, 32'h00, 1'b1);
        rdchk("unaligned", 8'h02, 32'h00, 1'b1);
        idle();
    endtask

    task automatic t_setup();
        logic [15:0] dly [5];
        dly = '{16'h4, 16'h2, 16'h0, 16'h9, 16'h3};
        // Ch0 master, ch1..4 slaves of it, input edge field left 00
        for (int c = 0; c < 5; c++) begin
            wr(adr(mspt_pkg::GRP_MODE, c), (c == 0) ? 32'h0001 : 32'h0409);
            wr(adr(mspt_pkg::GRP_RELOAD, c), {16'h0, dly[c]});
        end
        // Mode, polarity, level, then enable
        wr(mspt_pkg::OFS_OM, 32'h1E);
        wr(mspt_pkg::OFS_POL, 32'h04);
        wr(mspt_pkg::OFS_LVL, 32'h14);
        wr(mspt_pkg::OFS_OE, 32'h0E);
        idle();
        measure(10, 8'h0, 8'h0, 8'h0, 8'h0A, 8'h0, 8'h0A);
        wr(mspt_pkg::OFS_START, 32'h1F);
        req <= '0;
        // Pulse stands for the cycle after the start write
        @(negedge i_core_clk);
        `CHK("start pulse", 1'b1, irq[0])
        @(posedge i_core_clk);
        repeat (8) @(posedge i_core_clk);
        measure(10, 8'h2, 8'h2, 8'h4, 8'h0A, 8'h0A, 8'h0A);
    endtask

    task automatic t_rewrite();
        int n;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (irq[0] !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        // Next pulse edge is one period (reload 4 plus 1) later
        repeat (5) @(posedge i_core_clk);
        // Both reloads written right after the master pulse
        wr(adr(mspt_pkg::GRP_RELOAD, 0), 32'h6);
        wr(adr(mspt_pkg::GRP_RELOAD, 1), 32'h3);
        idle();
        repeat (16) @(posedge i_core_clk);
        measure(14, 8'h2, 8'h2, 8'h6, 8'h0E, 8'h0E, 8'h0E);
    endtask

    task automatic t_tapb();
        wr(mspt_pkg::OFS_STOP, 32'h1F);
        rdchk("run flags stopped", mspt_pkg::OFS_RUN, 32'h00, 1'b0);
        wr(mspt_pkg::OFS_CTRL, 32'h101);
        for (int c = 0; c < 5; c++) begin
            wr(adr(mspt_pkg::GRP_MODE, c), (c == 0) ? 32'h8001 : 32'h8409);
        end
        wr(mspt_pkg::OFS_START, 32'h1F);
        rdchk("run flags started", mspt_pkg::OFS_RUN, 32'h1F, 1'b0);
        idle();
        repeat (30) @(posedge i_core_clk);
        measure(28, 8'h2, 8'h2, 8'h0C, 8'h1C, 8'h1C, 8'h1C);
    endtask

    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        t_power();
        t_setup();
        t_rewrite();
        t_tapb();
        results();
    end

    // Whole run needs a few hundred cycles
    initial begin
        repeat (3000) @(posedge i_core_clk);
        failures++;
        results();
    end
endmodule
`default_nettype wire
